// ===== chip_cfg_regs.vh
`ifndef CHIP_CFG_REGS_VH
`define CHIP_CFG_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_W              12
`define OFF_PORT_CONFIG     12'h000
`define OFF_PART_IDENTITY   12'h001
`define OFF_SPEED_GRADE     12'h002
`define OFF_CHAN_SEL_HIGH   12'h004
`define OFF_CHAN_SEL_LOW    12'h005
`define OFF_CONFIG_UPDATE   12'h0FF

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PORT_CONFIG     8'h18
`define RST_SPEED_GRADE     8'h00
`define RST_CHAN_SEL_HIGH   8'h0F
`define RST_CHAN_SEL_LOW    8'h3F
`define RST_CONFIG_UPDATE   8'h00
// arbitrary identity value
`define PART_IDENTITY_VAL   8'h5C

// ----------------------------------------
// field positions
// ----------------------------------------
`define PC_LSB_FIRST_LO     1
`define PC_SOFT_RST_LO      2
`define PC_SOFT_RST_HI      5
`define PC_LSB_FIRST_HI     6
`define SG_MODE_HI          5
`define SG_MODE_LO          4
`define CS_FIXED_MASK       8'h30
`define CS_CHAN_MASK        8'h0F
`define CU_SPEED_BIT        0

`endif

// ===== port_config_mirror.v
`timescale 1ns/1ns
// merges the two mirrored nibbles of a port config write
module port_config_mirror (
   input  wire [7:0] wdata_in,
   output wire       lsb_first_out,
   output wire       soft_rst_out,
   output wire [7:0] stored_out
);
`include "chip_cfg_regs.vh"

   // either copy set counts, so shift order at write time does not matter
   assign lsb_first_out = wdata_in[`PC_LSB_FIRST_LO] | wdata_in[`PC_LSB_FIRST_HI];
   assign soft_rst_out  = wdata_in[`PC_SOFT_RST_LO] | wdata_in[`PC_SOFT_RST_HI];
   assign stored_out    = {1'b0, lsb_first_out, soft_rst_out, 2'b11,
                           soft_rst_out, lsb_first_out, 1'b0};
endmodule

// ===== chip_config_registers.v
`timescale 1ns/1ns
`include "chip_cfg_regs.vh"

// Contract
// - port config holds bit-order and soft-reset flags mirrored in both nibbles.
// - soft reset restores every register to default except port config.
// - soft-reset flag bits 2 and 5 self-clear after the soft reset.
// - high channel select bits 3:0 enable channels H..E, default 1.
// - low channel select bits 3:0 enable D..A, bits 5:4 fixed 1, reset 3F.
module chip_config_registers (
   input  wire                sys_clk_in,
   input  wire                rst_n_in,
   input  wire                wr_en_in,
   input  wire                rd_en_in,
   input  wire [`ADDR_W-1:0]  addr_in,
   input  wire [7:0]          wdata_in,
   output reg  [7:0]          rdata_out,
   output reg                 rvalid_out,
   output reg                 lsb_first_out,
   output reg  [1:0]          speed_mode_out,
   output reg  [7:0]          chan_enable_out,
   output reg                 link_defaults_out,
   output reg                 analog_defaults_out
);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg  [7:0] port_config;
   reg  [7:0] speed_grade;
   reg  [7:0] channel_select_high;
   reg  [7:0] channel_select_low;
   reg  [7:0] config_update;
   reg        grade_written;
   reg        soft_rst_pend;

   wire       mir_lsb;
   wire       mir_rst;
   wire [7:0] mir_val;

   port_config_mirror u_mirror (
      .wdata_in      (wdata_in),
      .lsb_first_out (mir_lsb),
      .soft_rst_out  (mir_rst),
      .stored_out    (mir_val)
   );

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // full twelve-bit compare, so aliases of the low byte never hit
   function hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   wire wr_pc  = wr_en_in & hit(addr_in, `OFF_PORT_CONFIG);
   wire wr_sg  = wr_en_in & hit(addr_in, `OFF_SPEED_GRADE);
   wire wr_csh = wr_en_in & hit(addr_in, `OFF_CHAN_SEL_HIGH);
   wire wr_csl = wr_en_in & hit(addr_in, `OFF_CHAN_SEL_LOW);
   wire wr_cu  = wr_en_in & hit(addr_in, `OFF_CONFIG_UPDATE);

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // soft reset takes one cycle: flags show set for one cycle, then clear
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_config         <= `RST_PORT_CONFIG;
         speed_grade         <= `RST_SPEED_GRADE;
         channel_select_high <= `RST_CHAN_SEL_HIGH;
         channel_select_low  <= `RST_CHAN_SEL_LOW;
         config_update       <= `RST_CONFIG_UPDATE;
         grade_written       <= 1'b0;
         soft_rst_pend       <= 1'b0;
      end else if (soft_rst_pend) begin
         // port config keeps its bit order; only the reset copies drop
         port_config[`PC_SOFT_RST_LO] <= 1'b0;
         port_config[`PC_SOFT_RST_HI] <= 1'b0;
         speed_grade         <= `RST_SPEED_GRADE;
         channel_select_high <= `RST_CHAN_SEL_HIGH;
         channel_select_low  <= `RST_CHAN_SEL_LOW;
         config_update       <= `RST_CONFIG_UPDATE;
         grade_written       <= 1'b0;
         soft_rst_pend       <= 1'b0;
      end else begin
         if (wr_pc) begin
            port_config   <= mir_val;
            soft_rst_pend <= mir_rst;
         end
         if (wr_sg) begin
            speed_grade   <= wdata_in;
            grade_written <= 1'b1;
         end
         if (wr_csh)
            channel_select_high <= wdata_in & `CS_CHAN_MASK;
         if (wr_csl)
            channel_select_low  <= (wdata_in & `CS_CHAN_MASK) | `CS_FIXED_MASK;
         if (wr_cu) begin
            config_update <= wdata_in;
            // a load of defaults re-arms the written condition
            if (grade_written)
               grade_written <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // bit order
   // ----------------------------------------
   // the mirror keeps both copies equal, so the low copy is enough
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lsb_first_out <= 1'b0;
      end else begin
         lsb_first_out <= port_config[`PC_LSB_FIRST_LO];
      end
   end

   // ----------------------------------------
   // speed mode
   // ----------------------------------------
   // new speed mode only applied on update, not on grade write
   wire apply_mode = wr_cu & grade_written & ~soft_rst_pend;

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         speed_mode_out <= 2'b00;
      end else if (soft_rst_pend) begin
         speed_mode_out <= 2'b00;
      end else if (apply_mode) begin
         speed_mode_out <= speed_grade[`SG_MODE_HI:`SG_MODE_LO];
      end
   end

   // ----------------------------------------
   // channel enables
   // ----------------------------------------
   // one bit per channel, A at bit 0 up to H at bit 7
   wire [7:0] next_chan;

   genvar ch;
   generate
      for (ch = 0; ch < 8; ch = ch + 1) begin : g_chan
         if (ch < 4) begin : g_low
            assign next_chan[ch] = channel_select_low[ch];
         end else begin : g_high
            assign next_chan[ch] = channel_select_high[ch-4];
         end
      end
   endgenerate

   // one edge behind the register, so a write shows two edges later
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chan_enable_out <= 8'hFF;
      end else begin
         chan_enable_out <= next_chan;
      end
   end

   // ----------------------------------------
   // default-load pulses
   // ----------------------------------------
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         link_defaults_out   <= 1'b0;
         analog_defaults_out <= 1'b0;
      end else begin
         link_defaults_out   <= soft_rst_pend;
         // link, port config and grade 5:4 untouched by this pulse
         analog_defaults_out <= soft_rst_pend |
                                (wr_cu & grade_written);
      end
   end

   // ----------------------------------------
   // reads
   // ----------------------------------------
   reg [7:0] next_rdata;
   always @* begin
      case (addr_in)
         `OFF_PORT_CONFIG:   next_rdata = port_config;
         `OFF_PART_IDENTITY: next_rdata = `PART_IDENTITY_VAL;
         `OFF_SPEED_GRADE:   next_rdata = speed_grade;
         `OFF_CHAN_SEL_HIGH: next_rdata = channel_select_high;
         `OFF_CHAN_SEL_LOW:  next_rdata = channel_select_low;
         `OFF_CONFIG_UPDATE: next_rdata = config_update;
         default:            next_rdata = 8'h00;
      endcase
   end

   // data holds between reads so a slow host can fetch it late
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (rd_en_in) begin
         rdata_out <= next_rdata;
      end
   end

   // ----------------------------------------
   // read strobe
   // ----------------------------------------
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= rd_en_in;
      end
   end
endmodule

// ===== cfg_regs_chk.sv
`timescale 1ns/1ns
module cfg_regs_chk (
   input wire logic        sys_clk_in, rst_n_in, wr_en_in, rd_en_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0]  wdata_in, rdata_out, chan_enable_out,
   input wire logic        rvalid_out, lsb_first_out, link_defaults_out, analog_defaults_out,
   input wire logic [1:0]  speed_mode_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic pc_wr = wr_en_in && addr_in == 12'h000;
   wire logic sr_wr = pc_wr && (wdata_in[2] || wdata_in[5]);
   AST_MIRROR: assert property (pc_wr && !wdata_in[2] && !wdata_in[5] |->
      ##2 lsb_first_out == $past(wdata_in[1] | wdata_in[6], 2)) else $error("bit order");
   AST_SOFT: assert property (sr_wr |-> ##2 link_defaults_out && analog_defaults_out)
      else $error("soft reset pulses");
   AST_SELF_CLR: assert property (sr_wr |-> ##2 link_defaults_out ##1 !link_defaults_out)
      else $error("soft reset repeats");
   AST_CHAN_HI: assert property (wr_en_in && addr_in == 12'h004 |->
      ##2 chan_enable_out[7:4] == $past(wdata_in[3:0], 2)) else $error("high enables");
   AST_CHAN_LO: assert property (wr_en_in && addr_in == 12'h005 |->
      ##2 chan_enable_out[3:0] == $past(wdata_in[3:0], 2)) else $error("low enables");
   AST_UPD_NOLINK: assert property (wr_en_in && addr_in == 12'h0FF |->
      ##1 !link_defaults_out [*2]) else $error("update hit link");
   cover property (link_defaults_out);
   cover property (analog_defaults_out && !link_defaults_out);
   cover property (rvalid_out);
endmodule
bind chip_config_registers cfg_regs_chk chk_u (.sys_clk_in, .rst_n_in, .wr_en_in, .rd_en_in,
   .addr_in, .wdata_in, .rdata_out, .chan_enable_out, .rvalid_out, .lsb_first_out,
   .link_defaults_out, .analog_defaults_out, .speed_mode_out);

// ===== host_model.sv
`timescale 1ns/1ns
module host_model (
   input  wire logic        clk,
   input  wire logic [7:0]  rdata,
   output logic             wr_en,
   output logic             rd_en,
   output logic [11:0]      addr,
   output logic [7:0]       wdata
);
   initial begin
      wr_en = 0; rd_en = 0; addr = 0; wdata = 0;
   end
   // released lines show the inverse so stale values never look valid
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk) #1 wr_en = 1; addr = a; wdata = d;
      @(posedge clk) #1 wr_en = 0; addr = ~a; wdata = ~d;
   endtask
   task rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk) #1 rd_en = 1; addr = a;
      @(posedge clk) #1 rd_en = 0; addr = ~a; d = rdata;
   endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ns
`include "chip_cfg_regs.vh"
module tb;
   logic sys_clk_in = 0, rst_n_in = 0, wr_en, rd_en, rvalid, lsb, lnk, ana;
   logic [11:0] addr;
   logic [7:0]  wdata, rdata, chan, r, v;
   logic [1:0]  spd;
   int bad_count = 0, n_checks = 0, cyc = 0, seed = 67, ana_n = 0, lnk_n = 0;
   initial forever #5 sys_clk_in = ~sys_clk_in;
   // each default-load pulse stands one cycle, so it is seen at one edge
   always @(posedge sys_clk_in) begin
      if (ana === 1'b1) ana_n++;
      if (lnk === 1'b1) lnk_n++;
   end
   chip_config_registers dut_u (.sys_clk_in, .rst_n_in, .wr_en_in(wr_en), .rd_en_in(rd_en),
      .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid),
      .lsb_first_out(lsb), .speed_mode_out(spd), .chan_enable_out(chan),
      .link_defaults_out(lnk), .analog_defaults_out(ana));
   host_model host_u (.clk(sys_clk_in), .rdata, .wr_en, .rd_en, .addr, .wdata);
   task chk(input logic [7:0] g, e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rc(input logic [11:0] a, input logic [7:0] e);
      host_u.rd(a, r);
      chk({7'h0, rvalid}, 8'h01);
      chk(r, e);
   endtask
   // soft-reset copies always read back cleared
   function logic [7:0] pc_exp(input logic [7:0] d);
      return {1'b0, d[1] | d[6], 3'b011, 1'b0, d[1] | d[6], 1'b0};
   endfunction
   task stop_test;
      if (bad_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge sys_clk_in) if (++cyc == 3000) begin
      bad_count++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge sys_clk_in);
      #1 rst_n_in = 1;
      rc(12'h000, 8'h18);
      rc(12'h004, 8'h0F);
      rc(12'h005, 8'h3F);
      rc(12'h003, 8'h00);
      chk(chan, 8'hFF);
      host_u.wr(12'h001, 8'hA5);
      rc(12'h001, `PART_IDENTITY_VAL);
      host_u.wr(12'h000, 8'h02);
      rc(12'h000, pc_exp(8'h02));
      chk({7'h0, lsb}, 8'h01);
      host_u.wr(12'h000, 8'h40);
      rc(12'h000, pc_exp(8'h40));
      chk({7'h0, lsb}, 8'h01);
      repeat (8) begin
         v = 8'($random(seed));
         host_u.wr(12'h004, v);
         host_u.wr(12'h005, ~v);
         rc(12'h004, {4'h0, v[3:0]});
         rc(12'h005, {4'h3, ~v[3:0]});
         chk(chan, {v[3:0], ~v[3:0]});
      end
      host_u.wr(12'h002, 8'h20);
      host_u.wr(12'h0FF, 8'h01);
      rc(12'h0FF, 8'h01);
      chk({6'h0, spd}, 8'h02);
      chk(8'(ana_n), 8'h01);
      host_u.wr(12'h002, 8'h10);
      rc(12'h0FF, 8'h01);
      chk({6'h0, spd}, 8'h02);
      host_u.wr(12'h0FF, 8'h00);
      rc(12'h0FF, 8'h00);
      chk({6'h0, spd}, 8'h01);
      chk(8'(ana_n), 8'h02);
      chk(8'(lnk_n), 8'h00);
      host_u.wr(12'h004, 8'h03);
      host_u.wr(12'h000, 8'h7E);
      rc(12'h000, pc_exp(8'h7E));
      rc(12'h004, 8'h0F);
      chk(chan, 8'hFF);
      chk({6'h0, spd}, 8'h00);
      chk(8'(lnk_n), 8'h01);
      chk(8'(ana_n), 8'h03);
      // update with no grade write since the defaults load does nothing
      host_u.wr(12'h0FF, 8'h01);
      rc(12'h0FF, 8'h01);
      chk({6'h0, spd}, 8'h00);
      chk(8'(ana_n), 8'h03);
      stop_test;
   end
endmodule
